// >>> dma_ch_slot.sv
/*
 * One channel's control state: enable, pending trigger, busy, abort,
 * priority and next-descriptor selector.
 * Assumes control strobes are one-cycle pulses synchronous to core_clk.
 */
`timescale 1ns/10ps
module dma_ch_slot (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic enSet,
	input wire logic enClr,
	input wire logic swTrig,
	input wire logic hwTrig,
	input wire logic grant,
	input wire logic xferDone,
	input wire logic prioWr,
	input wire logic [1:0] prioIn,
	input wire logic descWr,
	input wire logic descIn,
	output logic enable,
	output logic pending,
	output logic busy,
	output logic abortPulse,
	output logic [1:0] prio,
	output logic nextDesc
);
	dma_ctrl_pkg::ch_state_type state_r, state_nxt;
	logic enable_r, abort_r;
	logic [1:0] prio_r;
	logic desc_r;
	wire logic trigEvt = swTrig | hwTrig;
	wire logic enNext = enSet | (enable_r & ~enClr);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			dma_ctrl_pkg::CH_IDLE: if (enNext && trigEvt) state_nxt = dma_ctrl_pkg::CH_PEND;
			dma_ctrl_pkg::CH_PEND: begin
				if (!enNext) state_nxt = dma_ctrl_pkg::CH_IDLE;
				else if (grant) state_nxt = dma_ctrl_pkg::CH_BUSY;
			end
			dma_ctrl_pkg::CH_BUSY: begin
				// Disable cuts the transfer short rather than letting it finish
				if (!enNext || xferDone) state_nxt = dma_ctrl_pkg::CH_IDLE;
			end
			default: state_nxt = dma_ctrl_pkg::CH_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_r <= dma_ctrl_pkg::CH_IDLE;
			enable_r <= dma_ctrl_pkg::EN_RST;
			abort_r <= 1'b0;
			prio_r <= dma_ctrl_pkg::PRIO_RST;
			desc_r <= dma_ctrl_pkg::DESC_SEL_RST;
		end else begin
			state_r <= state_nxt;
			enable_r <= enNext;
			abort_r <= (state_r == dma_ctrl_pkg::CH_BUSY) && !enNext;
			if (prioWr) prio_r <= prioIn;
			if (descWr) desc_r <= descIn;
		end
	end

	assign enable = enable_r;
	assign pending = (state_r == dma_ctrl_pkg::CH_PEND);
	assign busy = (state_r == dma_ctrl_pkg::CH_BUSY);
	assign abortPulse = abort_r;
	assign prio = prio_r;
	assign nextDesc = desc_r;
endmodule // dma_ch_slot

// >>> dma_channel_ctrl.sv
/*
 * Multi-channel DMA control and interrupt aggregation: per-channel
 * enable, firmware trigger, priority, next descriptor, arbitration and
 * raw/mask/masked interrupt views with one combined interrupt.
 * Assumes the transfer engine pulses xferDone and chIrqReq per channel.
 */
// How it works
// - Masked view equals raw AND mask.
// - Mask register written and read back.
// - Clearing enable aborts in-flight transfer.
// - Firmware write triggers selected channel.
// - Two-bit priority, zero is highest.
// - One-bit next descriptor selector per channel.
// - Raw interrupt bit set per request.
// - Write-one clears selected raw bits.
`timescale 1ns/10ps
module dma_channel_ctrl #(
	parameter int NCH = dma_ctrl_pkg::NUM_CH
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [NCH-1:0] chEnableSet,
	input wire logic [NCH-1:0] chEnableClr,
	input wire logic [NCH-1:0] fwTrigger,
	input wire logic [NCH-1:0] hwTrigger,
	input wire logic [NCH-1:0] prioWrite,
	input wire logic [2*NCH-1:0] prioWrData,
	input wire logic [NCH-1:0] descWrite,
	input wire logic [NCH-1:0] descWrData,
	input wire logic maskWrite,
	input wire logic [NCH-1:0] maskWrData,
	input wire logic [NCH-1:0] irqClear,
	input wire logic [NCH-1:0] chIrqReq,
	input wire logic [NCH-1:0] xferDone,
	output logic [NCH-1:0] chEnabled,
	output logic [NCH-1:0] chPending,
	output logic [NCH-1:0] chBusy,
	output logic [NCH-1:0] chAbort,
	output logic [2*NCH-1:0] chPrio,
	output logic [NCH-1:0] chNextDesc,
	output logic grantValid,
	output logic [NCH-1:0] grantOneHot,
	output logic [NCH-1:0] irqRaw,
	output logic [NCH-1:0] irqMask,
	output logic [NCH-1:0] irqMasked,
	output logic irqOut
);
	// ----------------------------------------
	// Channel slots
	// ----------------------------------------
	logic [NCH-1:0] irqRaw_r, irqMask_r;
	logic [NCH-1:0] grant_r;
	logic [NCH-1:0] grantNxt;
	wire logic engineBusy = |chBusy;

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			dma_ch_slot u_slot (
				.core_clk(core_clk),
				.srst(srst),
				.enSet(chEnableSet[g]),
				.enClr(chEnableClr[g]),
				.swTrig(fwTrigger[g]),
				.hwTrig(hwTrigger[g]),
				.grant(grantNxt[g]),
				.xferDone(xferDone[g]),
				.prioWr(prioWrite[g]),
				.prioIn(prioWrData[2*g +: 2]),
				.descWr(descWrite[g]),
				.descIn(descWrData[g]),
				.enable(chEnabled[g]),
				.pending(chPending[g]),
				.busy(chBusy[g]),
				.abortPulse(chAbort[g]),
				.prio(chPrio[2*g +: 2]),
				.nextDesc(chNextDesc[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Arbitration
	// ----------------------------------------
	// Lowest priority value wins; ties go to the lowest channel number.
	// Only one transfer runs at a time, so no grant while busy.
	// A channel being disabled this cycle is not offered the grant, so every
	// grant pulse matches a channel that really goes busy.
	wire logic [NCH-1:0] stayEn = chEnableSet | (chEnabled & ~chEnableClr);
	wire logic [NCH-1:0] candidate = chPending & stayEn;

	always_comb begin
		logic [1:0] best;
		logic found;
		best = 2'h3;
		found = 1'b0;
		grantNxt = '0;
		for (int i = 0; i < NCH; i++) begin
			if (candidate[i] && (!found || chPrio[2*i +: 2] < best)) begin
				best = chPrio[2*i +: 2];
				found = 1'b1;
			end
		end
		for (int i = 0; i < NCH; i++) begin
			if (!engineBusy && found && grantNxt == '0 && candidate[i]
					&& chPrio[2*i +: 2] == best) begin
				grantNxt[i] = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Arbitration checks
	// ----------------------------------------
	grant_one_a: assert property (@(posedge core_clk) disable iff (srst)
		$onehot0(grantNxt)) else $error("more than one grant");
	one_busy_a: assert property (@(posedge core_clk) disable iff (srst)
		$onehot0(chBusy)) else $error("two channels busy");
	grant_busy_a: assert property (@(posedge core_clk) disable iff (srst)
		grantValid |-> (chBusy & grantOneHot) == grantOneHot)
		else $error("grant without busy channel");
	grant_pulse_a: assert property (@(posedge core_clk) disable iff (srst)
		grantValid |=> !grantValid) else $error("grant held too long");
	// Channel 3 beats channel 0 only on a strictly lower value; a tie keeps 0
	prio_win_a: assert property (@(posedge core_clk) disable iff (srst)
		(chPending[0] && chPending[3] && !engineBusy && chEnableClr == '0)
		|-> ((chPrio[7:6] < chPrio[1:0]) ? !grantNxt[0] : !grantNxt[3]))
		else $error("lower priority granted");

	// ----------------------------------------
	// Interrupt views
	// ----------------------------------------
	// Set beats clear so a request arriving with its clear is kept
	wire logic [NCH-1:0] rawNxt = (irqRaw_r & ~irqClear) | chIrqReq;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			irqRaw_r <= '0;
			irqMask_r <= {NCH{dma_ctrl_pkg::MASK_RST}};
			grant_r <= '0;
		end else begin
			irqRaw_r <= rawNxt;
			if (maskWrite) irqMask_r <= maskWrData;
			grant_r <= grantNxt;
		end
	end

	assign grantOneHot = grant_r;
	assign grantValid = |grant_r;
	assign irqRaw = irqRaw_r;
	assign irqMask = irqMask_r;
	assign irqMasked = irqRaw_r & irqMask_r;
	assign irqOut = |irqMasked;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Helper terms let one property cover every channel at once
	wire logic [NCH-1:0] cutBusy = chBusy & chEnableClr & ~chEnableSet;
	wire logic [NCH-1:0] cutPend = chPending & chEnableClr & ~chEnableSet;
	wire logic [NCH-1:0] trigIdle = fwTrigger & chEnabled & ~chEnableClr & ~chPending & ~chBusy;
	wire logic [NCH-1:0] trigOff = (fwTrigger | hwTrigger) & ~chEnabled & ~chEnableSet;
	wire logic [NCH-1:0] clrOnly = irqClear & ~chIrqReq;

	en_set_a: assert property (@(posedge core_clk) disable iff (srst)
		chEnableSet != '0 |=> (chEnabled & $past(chEnableSet)) == $past(chEnableSet))
		else $error("enable set lost");
	enable_hold_a: assert property (@(posedge core_clk) disable iff (srst)
		(chEnableSet == '0 && chEnableClr == '0) |=> $stable(chEnabled))
		else $error("enable changed unwritten");
	disable_abort_a: assert property (@(posedge core_clk) disable iff (srst)
		cutBusy != '0 |=> (chAbort & $past(cutBusy)) == $past(cutBusy)
			&& (chBusy & $past(cutBusy)) == '0)
		else $error("disable did not abort");
	abort_pulse_a: assert property (@(posedge core_clk) disable iff (srst)
		chAbort != '0 |=> (chAbort & $past(chAbort)) == '0)
		else $error("abort longer than a cycle");
	pend_drop_a: assert property (@(posedge core_clk) disable iff (srst)
		cutPend != '0 |=> ((chPending | chBusy) & $past(cutPend)) == '0)
		else $error("disabled channel kept its request");
	fw_trig_a: assert property (@(posedge core_clk) disable iff (srst)
		trigIdle != '0 |=> ((chPending | chBusy) & $past(trigIdle)) == $past(trigIdle))
		else $error("trigger lost");
	trig_refuse_a: assert property (@(posedge core_clk) disable iff (srst)
		trigOff != '0 |=> ((chPending | chBusy) & $past(trigOff)) == '0)
		else $error("disabled channel took a trigger");
	prio_store_a: assert property (@(posedge core_clk) disable iff (srst)
		prioWrite[0] |=> chPrio[1:0] == $past(prioWrData[1:0])) else $error("prio not stored");
	prio_keep_a: assert property (@(posedge core_clk) disable iff (srst)
		prioWrite == '0 |=> $stable(chPrio)) else $error("prio changed unwritten");
	desc_store_a: assert property (@(posedge core_clk) disable iff (srst)
		descWrite != '0
		|=> (chNextDesc & $past(descWrite)) == ($past(descWrData) & $past(descWrite)))
		else $error("desc not stored");
	desc_keep_a: assert property (@(posedge core_clk) disable iff (srst)
		descWrite == '0 |=> $stable(chNextDesc)) else $error("desc changed unwritten");

	// ----------------------------------------
	// Interrupt checks
	// ----------------------------------------
	masked_view_a: assert property (@(posedge core_clk) disable iff (srst)
		maskWrite |=> (irqMasked & ~$past(maskWrData)) == '0)
		else $error("masked view shows a masked-off bit");
	masked_pass_a: assert property (@(posedge core_clk) disable iff (srst)
		(!maskWrite && (chIrqReq & irqMask) != '0)
		|=> (irqMasked & $past(chIrqReq)) == ($past(chIrqReq) & irqMask))
		else $error("masked view dropped a raw bit");
	mask_hold_a: assert property (@(posedge core_clk) disable iff (srst)
		maskWrite |=> irqMask == $past(maskWrData)) else $error("mask not stored");
	mask_keep_a: assert property (@(posedge core_clk) disable iff (srst)
		!maskWrite |=> $stable(irqMask)) else $error("mask changed unwritten");
	raw_set_a: assert property (@(posedge core_clk) disable iff (srst)
		chIrqReq != '0 |=> (irqRaw & $past(chIrqReq)) == $past(chIrqReq))
		else $error("request lost");
	raw_hold_a: assert property (@(posedge core_clk) disable iff (srst)
		(chIrqReq == '0 && irqClear == '0) |=> $stable(irqRaw))
		else $error("raw bit changed without cause");
	raw_clr_a: assert property (@(posedge core_clk) disable iff (srst)
		clrOnly != '0 |=> (irqRaw & $past(clrOnly)) == '0)
		else $error("clear ignored");
	irq_out_a: assert property (@(posedge core_clk) disable iff (srst)
		(!maskWrite && (chIrqReq & irqMask) != '0) |=> irqOut)
		else $error("irq output missing");
	irq_drop_a: assert property (@(posedge core_clk) disable iff (srst)
		((irqRaw & ~irqClear) == '0 && chIrqReq == '0) |=> !irqOut)
		else $error("irq output stuck");
endmodule // dma_channel_ctrl

// >>> dma_ctrl_pkg.sv
/*
 * Constants shared by the DMA channel control and interrupt block.
 * Assumes a single clock domain and a synchronous active-high reset.
 */
package dma_ctrl_pkg;
	localparam int NUM_CH = 8;
	localparam int PRIO_W = 2;
	localparam logic [1:0] PRIO_RST = 2'h0;
	localparam logic [1:0] PRIO_HIGHEST = 2'h0;
	localparam logic DESC_SEL_RST = 1'h0;
	localparam logic MASK_RST = 1'h0;
	localparam logic EN_RST = 1'h0;

	typedef enum logic [1:0] {
		CH_IDLE = 2'b00,
		CH_PEND = 2'b01,
		CH_BUSY = 2'b10
	} ch_state_type;
endpackage

// >>> tb_top.sv
/*
 * Self-checking bench for the DMA channel control and interrupt block.
 * Assumes the default channel count and one-cycle strobes on core_clk.
 */
`timescale 1ns/10ps
module tb_top;
	logic core_clk;
	logic srst;
	logic [7:0] enS, enC, fw, hw, pw, dw, dd, md, ic, rq, xd;
	logic [15:0] pd;
	logic mw;
	logic [7:0] en, pe, bu, ab, nd, gh, raw, msk, mkd;
	logic [15:0] pr;
	logic gv, io;
	int n_errors = 0;
	int n_checks = 0;
	dma_channel_ctrl dut (.core_clk(core_clk), .srst(srst), .chEnableSet(enS),
		.chEnableClr(enC), .fwTrigger(fw), .hwTrigger(hw), .prioWrite(pw),
		.prioWrData(pd), .descWrite(dw), .descWrData(dd), .maskWrite(mw),
		.maskWrData(md), .irqClear(ic), .chIrqReq(rq), .xferDone(xd),
		.chEnabled(en), .chPending(pe), .chBusy(bu), .chAbort(ab), .chPrio(pr),
		.chNextDesc(nd), .grantValid(gv), .grantOneHot(gh), .irqRaw(raw),
		.irqMask(msk), .irqMasked(mkd), .irqOut(io));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic step;
		@(posedge core_clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic give_verdict;
		$display("checks=%0d errors=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_irq;
		rq = 8'h5a;
		mw = 1'h1;
		md = 8'h0f;
		step;
		rq = 8'h00;
		mw = 1'h0;
		chk(16'(raw), 16'h005a);
		chk(16'(msk), 16'h000f);
		chk(16'(mkd), 16'h000a);
		chk(16'(io), 16'h0001);
		ic = 8'h0a;
		step;
		ic = 8'h00;
		chk(16'(raw), 16'h0050);
		chk(16'(io), 16'h0000);
		chk(16'(msk), 16'h000f);
		// A request meeting its own clear must survive
		rq = 8'h01;
		ic = 8'h41;
		step;
		rq = 8'h00;
		ic = 8'h00;
		chk(16'(raw), 16'h0011);
		chk(16'(mkd), 16'h0001);
		chk(16'(io), 16'h0001);
		ic = 8'h11;
		step;
		ic = 8'h00;
		chk(16'(raw), 16'h0000);
		chk(16'(io), 16'h0000);
	endtask
	task automatic t_cfg;
		// Priorities of channels 0 to 3 run opposite to index so a tie-break cannot fake the result
		pw = 8'hff;
		pd = 16'h001b;
		dw = 8'hff;
		dd = 8'haa;
		step;
		pw = 8'h00;
		dw = 8'h00;
		chk(pr, 16'h001b);
		chk(16'(nd), 16'h00aa);
	endtask
	task automatic t_xfer;
		enS = 8'h09;
		step;
		enS = 8'h00;
		chk(16'(en), 16'h0009);
		fw = 8'h09;
		step;
		fw = 8'h00;
		chk(16'(pe), 16'h0009);
		step;
		chk(16'(bu), 16'h0008);
		chk(16'(gh), 16'h0008);
		chk(16'(gv), 16'h0001);
		hw = 8'h02;
		step;
		hw = 8'h00;
		chk(16'(gh), 16'h0000);
		chk(16'(pe[1]), 16'h0000);
		enC = 8'h08;
		step;
		enC = 8'h00;
		chk(16'(bu), 16'h0000);
		chk(16'(ab), 16'h0008);
		step;
		chk(16'(ab), 16'h0000);
		chk(16'(bu), 16'h0001);
		xd = 8'h01;
		step;
		xd = 8'h00;
		chk(16'(bu), 16'h0000);
	endtask
	task automatic t_drop;
		// Set and clear together: set wins
		enS = 8'h09;
		enC = 8'h01;
		step;
		enS = 8'h00;
		enC = 8'h00;
		chk(16'(en), 16'h0009);
		fw = 8'h09;
		step;
		fw = 8'h00;
		chk(16'(pe), 16'h0009);
		step;
		chk(16'(bu), 16'h0008);
		chk(16'(pe), 16'h0001);
		// Disabling a channel that waits behind a busy one drops its request
		enC = 8'h01;
		step;
		enC = 8'h00;
		chk(16'(pe), 16'h0000);
		chk(16'(ab), 16'h0000);
		chk(16'(en), 16'h0008);
		xd = 8'h08;
		step;
		xd = 8'h00;
		chk(16'(bu), 16'h0000);
		step;
		chk(16'(gh), 16'h0000);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		{enS, enC, fw, hw, pw, dw, dd, md, ic, rq, xd} = '0;
		pd = 16'h0000;
		mw = 1'h0;
		srst = 1'h1;
		repeat (12) @(posedge core_clk);
		#1;
		srst = 1'h0;
		chk(pr, 16'h0000);
		chk(16'(msk), 16'h0000);
		t_irq;
		t_cfg;
		t_xfer;
		t_drop;
		give_verdict;
	end
	// Tests need well under a hundred cycles; this leaves ample margin
	initial begin
		#100000;
		n_errors++;
		give_verdict;
	end
endmodule // tb_top
